// file: rtl/adcrr_pkg.sv
// adcrr_pkg: constants and types for the converter round-robin channel selector
// assumes: one 16-bit configuration register written through the serial config port
package adcrr_pkg;
  // ----------------------------------------------------------------
  // register layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 16;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int ON_LSB = 8;
  localparam int OFF_LSB = 0;
  localparam int SRC_N = 7;
  localparam logic [15:0] CFG_RW_MASK = 16'hffff;
  localparam int RES_W = 10;
  // ----------------------------------------------------------------
  // source slots: index i selects input/slot in visiting order
  // slot 0 input1, 1 input3, 2 input5, 3 input2, 4 input4, 5 input6, 6 die temp
  // ----------------------------------------------------------------
  localparam logic [2:0] SLOT_NONE_IDX = 3'h7;
  localparam logic [2:0] SLOT_FIRST = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h6;
  // converter mux code per slot: 1..6 analog inputs, 7 die temperature
  localparam logic [2:0] MUX_IN1 = 3'h1;
  localparam logic [2:0] MUX_IN3 = 3'h3;
  localparam logic [2:0] MUX_IN5 = 3'h5;
  localparam logic [2:0] MUX_IN2 = 3'h2;
  localparam logic [2:0] MUX_IN4 = 3'h4;
  localparam logic [2:0] MUX_IN6 = 3'h6;
  localparam logic [2:0] MUX_DIE = 3'h7;
  typedef enum logic [1:0] {ADCRR_IDLE, ADCRR_CONV, ADCRR_STORE} adcrr_state_t;
endpackage

// file: rtl/adcrr_next_slot.sv
// adcrr_next_slot: finds the next enabled slot after the current one
// assumes: purely combinational, used by the sequencer in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module adcrr_next_slot (
  input wire logic [6:0] i_enables,
  input wire logic [2:0] i_current,
  output logic o_found,
  output logic [2:0] o_next
);
  logic [2:0] idx;
  always_comb begin
    o_found = 1'b0;
    o_next = adcrr_pkg::SLOT_FIRST;
    idx = 3'h0;
    // search forward from current+1, wrapping die temp back to input1
    for (int k = 1; k <= adcrr_pkg::SRC_N; k++) begin
      idx = 3'((int'(i_current) + k) % adcrr_pkg::SRC_N);
      if (!o_found && i_enables[idx]) begin
        o_found = 1'b1;
        o_next = idx;
      end
    end
  end
endmodule // adcrr_next_slot
`default_nettype wire

// file: rtl/adcrr_channel_select.sv
// adcrr_channel_select: channel select register and round-robin sequencer
// assumes: serial config logic gives a one-cycle write strobe with 16-bit data;
// converter takes a start pulse with a mux code and answers with done + result
`timescale 1ns/1ps
`default_nettype none
module adcrr_channel_select (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_cfg_wr,
  input wire logic [15:0] i_cfg_wdata,
  input wire logic i_pwm_on,
  input wire logic i_conv_done,
  input wire logic [9:0] i_conv_result,
  output logic [15:0] o_conv_channel_select_cfg,
  output logic o_conv_start,
  output logic [2:0] o_conv_mux,
  output logic [9:0] o_result_slot1,
  output logic [9:0] o_result_slot2,
  output logic [9:0] o_result_slot3,
  output logic [9:0] o_result_slot4,
  output logic [9:0] o_result_slot5,
  output logic [9:0] o_result_slot6,
  output logic [9:0] o_result_slot7,
  output logic o_busy
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg;
    adcrr_pkg::adcrr_state_t state;
    logic [2:0] slot;
    logic busy;
    logic start;
    logic [2:0] mux;
    logic [6:0][9:0] result;
  } adcrr_regs_t;

  adcrr_regs_t r;
  adcrr_regs_t next_r;

  // slot order maps to analog input number for the converter mux
  function automatic logic [2:0] adcrr_mux_of(input logic [2:0] slot);
    case (slot)
      3'h0: adcrr_mux_of = adcrr_pkg::MUX_IN1;
      3'h1: adcrr_mux_of = adcrr_pkg::MUX_IN3;
      3'h2: adcrr_mux_of = adcrr_pkg::MUX_IN5;
      3'h3: adcrr_mux_of = adcrr_pkg::MUX_IN2;
      3'h4: adcrr_mux_of = adcrr_pkg::MUX_IN4;
      3'h5: adcrr_mux_of = adcrr_pkg::MUX_IN6;
      default: adcrr_mux_of = adcrr_pkg::MUX_DIE;
    endcase
  endfunction

  // result slot index: input1->0, input3->1, input5->2, input2->3, input4->4,
  // input6->5, die->6, which is the visiting slot itself (index 0 drives o_result_slot1)
  function automatic logic [2:0] adcrr_slot_of(input logic [2:0] slot);
    adcrr_slot_of = slot;
  endfunction

  // ----------------------------------------------------------------
  // enable selection
  // ----------------------------------------------------------------
  logic [6:0] on_en;
  logic [6:0] off_en;
  logic [6:0] act_en;
  logic next_found;
  logic [2:0] next_slot;

  // bit 8+i is on-phase slot i, bit i is off-phase slot i
  assign on_en = r.cfg[adcrr_pkg::ON_LSB +: adcrr_pkg::SRC_N];
  assign off_en = r.cfg[adcrr_pkg::OFF_LSB +: adcrr_pkg::SRC_N];
  // phase is taken at the choosing edge itself, so each source matches the phase live at its own choice
  assign act_en = i_pwm_on ? on_en : off_en;

  // starting from slot 6 makes the search begin at input1 after a wrap
  adcrr_next_slot u_next (
    .i_enables(act_en),
    .i_current((r.state == adcrr_pkg::ADCRR_IDLE) ? adcrr_pkg::SLOT_LAST : r.slot),
    .o_found(next_found),
    .o_next(next_slot)
  );

  // ----------------------------------------------------------------
  // source choice
  // ----------------------------------------------------------------
  // a choice is only acted on in idle and store, so a done pulse that
  // arrives outside a conversion can never start one
  logic launch;
  logic [2:0] launch_mux;

  always_comb begin
    launch = 1'b0;
    launch_mux = r.mux;
    case (r.state)
      adcrr_pkg::ADCRR_IDLE: begin
        launch = next_found;
      end
      adcrr_pkg::ADCRR_STORE: begin
        launch = next_found;
      end
      default: begin
        launch = 1'b0;
      end
    endcase
    if (launch) begin
      launch_mux = adcrr_mux_of(next_slot);
    end
  end

  // ----------------------------------------------------------------
  // result store decode
  // ----------------------------------------------------------------
  // one-hot write enable per result slot; a done pulse outside a
  // conversion leaves every slot untouched
  logic [6:0] store_hit;

  always_comb begin
    store_hit = 7'h00;
    if ((r.state == adcrr_pkg::ADCRR_CONV) && i_conv_done) begin
      store_hit[adcrr_slot_of(r.slot)] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    if (i_cfg_wr) begin
      // a write mid-run is used from the next source choice on
      next_r.cfg = i_cfg_wdata & adcrr_pkg::CFG_RW_MASK;
    end
    for (int n = 0; n < adcrr_pkg::SRC_N; n++) begin
      if (store_hit[n]) begin
        next_r.result[n] = i_conv_result;
      end
    end
    case (r.state)
      adcrr_pkg::ADCRR_IDLE: begin
        // a conversion in flight keeps its source even if the phase flips
        if (launch) begin
          next_r.slot = next_slot;
          next_r.mux = launch_mux;
          next_r.start = 1'b1;
          next_r.busy = 1'b1;
          next_r.state = adcrr_pkg::ADCRR_CONV;
        end
      end
      adcrr_pkg::ADCRR_CONV: begin
        if (i_conv_done) begin
          next_r.state = adcrr_pkg::ADCRR_STORE;
        end
      end
      adcrr_pkg::ADCRR_STORE: begin
        // follow the fixed order from the slot just stored
        if (launch) begin
          next_r.slot = next_slot;
          next_r.mux = launch_mux;
          next_r.start = 1'b1;
          next_r.state = adcrr_pkg::ADCRR_CONV;
        end else begin
          next_r.busy = 1'b0;
          next_r.state = adcrr_pkg::ADCRR_IDLE;
        end
      end
      default: begin
        next_r.busy = 1'b0;
        next_r.state = adcrr_pkg::ADCRR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      r.cfg <= adcrr_pkg::CFG_RESET;
      r.state <= adcrr_pkg::ADCRR_IDLE;
      r.slot <= adcrr_pkg::SLOT_LAST;
      r.busy <= 1'b0;
      r.start <= 1'b0;
      r.mux <= adcrr_pkg::MUX_IN1;
      r.result[0] <= 10'h000;
      r.result[1] <= 10'h000;
      r.result[2] <= 10'h000;
      r.result[3] <= 10'h000;
      r.result[4] <= 10'h000;
      r.result[5] <= 10'h000;
      r.result[6] <= 10'h000;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_conv_channel_select_cfg = r.cfg;
  assign o_conv_start = r.start;
  assign o_conv_mux = r.mux;
  assign o_result_slot1 = r.result[0];
  assign o_result_slot2 = r.result[1];
  assign o_result_slot3 = r.result[2];
  assign o_result_slot4 = r.result[3];
  assign o_result_slot5 = r.result[4];
  assign o_result_slot6 = r.result[5];
  assign o_result_slot7 = r.result[6];
  // busy has its own flop so the output never comes from a state decode
  assign o_busy = r.busy;
endmodule // adcrr_channel_select
`default_nettype wire

// file: tb/adcrr_cs_properties.sv
// checker: channel selector port relations
// assumes: bound to adcrr_channel_select, one clock
`timescale 1ns/1ps
`default_nettype none
module adcrr_cs_properties (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_cfg_wr,
  input wire logic [15:0] i_cfg_wdata,
  input wire logic i_pwm_on,
  input wire logic i_conv_done,
  input wire logic [9:0] i_conv_result,
  input wire logic [15:0] o_conv_channel_select_cfg,
  input wire logic o_conv_start,
  input wire logic [2:0] o_conv_mux,
  input wire logic [9:0] o_result_slot6,
  input wire logic [9:0] o_result_slot7,
  input wire logic o_busy
);
  localparam int SB [8] = '{6, 0, 3, 1, 4, 2, 5, 6};
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence s_taken;
    i_conv_done && o_busy && !o_conv_start;
  endsequence
  property p_store(logic [2:0] m, logic [9:0] slot);
    (s_taken ##0 o_conv_mux == m) |=> slot == $past(i_conv_result);
  endproperty
  chk_reset_clear: assert property (disable iff (1'b0)
    i_sys_rst |=> o_conv_channel_select_cfg == 16'h0000 && !o_busy) else $error("reset");
  chk_idle_quiet: assert property (o_conv_channel_select_cfg == 16'h0000 && !o_busy
    |=> !o_conv_start) else $error("start");
  chk_start_enabled: assert property (o_conv_start |-> (($past(o_conv_channel_select_cfg)
    >> (SB[o_conv_mux] + ($past(i_pwm_on) ? 8 : 0))) & 16'h0001) != 16'h0000) else $error("mux");
  chk_next_pick: assert property (s_taken |-> ##2 (o_conv_start || !o_busy))
    else $error("next");
  chk_start_pulse: assert property (o_conv_start |=> !o_conv_start) else $error("pulse");
  chk_die_store: assert property (p_store(3'h7, o_result_slot7)) else $error("slot7");
  chk_in6_store: assert property (p_store(3'h6, o_result_slot6)) else $error("slot6");
  chk_cfg_holds: assert property (i_cfg_wr |=>
    o_conv_channel_select_cfg == $past(i_cfg_wdata)) else $error("cfg");
  chk_start_busy: assert property (o_conv_start |-> o_busy ##1
    (o_busy && $stable(o_conv_mux))) else $error("busy");
endmodule // adcrr_cs_properties
bind adcrr_channel_select adcrr_cs_properties chk_u (
  .i_clock(i_clock),
  .i_sys_rst(i_sys_rst),
  .i_cfg_wr(i_cfg_wr),
  .i_cfg_wdata(i_cfg_wdata),
  .i_pwm_on(i_pwm_on),
  .i_conv_done(i_conv_done),
  .i_conv_result(i_conv_result),
  .o_conv_channel_select_cfg(o_conv_channel_select_cfg),
  .o_conv_start(o_conv_start),
  .o_conv_mux(o_conv_mux),
  .o_result_slot6(o_result_slot6),
  .o_result_slot7(o_result_slot7),
  .o_busy(o_busy)
);
`default_nettype wire

// file: tb/tb_adcrr_channel_select.sv
// bench: config writer and converter stand-in
// assumes: converter answers 2 to 5 cycles after a start
`timescale 1ns/1ps
`default_nettype none
module tb_adcrr_channel_select;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, i_cfg_wr = 1'b0, i_pwm_on = 1'b0, i_conv_done = 1'b0;
  logic o_conv_start, o_busy;
  logic [15:0] i_cfg_wdata = 16'h0000, o_conv_channel_select_cfg, w;
  logic [9:0] i_conv_result = 10'h000;
  wire [9:0] s [1:7];
  logic [2:0] o_conv_mux, q [$];
  int bad_count = 0, num_checks = 0, cyc = 0, seed = 32'h7e7a, k;
  localparam logic [2:0] ORD [7] = '{3'h1, 3'h3, 3'h5, 3'h2, 3'h4, 3'h6, 3'h7};
  localparam int SL [8] = '{1, 1, 4, 2, 5, 3, 6, 7};
  adcrr_channel_select dut_u (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_cfg_wr(i_cfg_wr),
    .i_cfg_wdata(i_cfg_wdata),
    .i_pwm_on(i_pwm_on),
    .i_conv_done(i_conv_done),
    .i_conv_result(i_conv_result),
    .o_conv_channel_select_cfg(o_conv_channel_select_cfg),
    .o_conv_start(o_conv_start),
    .o_conv_mux(o_conv_mux),
    .o_result_slot1(s[1]),
    .o_result_slot2(s[2]),
    .o_result_slot3(s[3]),
    .o_result_slot4(s[4]),
    .o_result_slot5(s[5]),
    .o_result_slot6(s[6]),
    .o_result_slot7(s[7]),
    .o_busy(o_busy)
  );
  always #2 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] a, input logic [15:0] e);
    num_checks++;
    if (a !== e) bad_count++;
    if (a !== e) $display("unexpected at %0t: %h not %h", $time, a, e);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic put(input logic [15:0] v);
    {i_cfg_wr, i_cfg_wdata} = {1'b1, v};
    @(negedge i_clock);
    i_cfg_wr = 1'b0;
  endtask
  // converter stand-in: at least 2 cycles so a stop write lands first
  always @(negedge i_clock) if (o_conv_start === 1'b1) begin
    check(16'(o_conv_mux), 16'(q.size() > 0 ? q.pop_front() : 3'h0));
    repeat (2 + ($random(seed) & 3)) @(negedge i_clock);
    {i_conv_done, i_conv_result} = {1'b1, 10'($random(seed))};
    @(negedge i_clock);
    i_conv_done = 1'b0;
    check(16'(s[SL[o_conv_mux]]), 16'(i_conv_result));
  end
  initial begin
    repeat (12) @(negedge i_clock);
    i_sys_rst = 1'b0;
    check(o_conv_channel_select_cfg, 16'h0000);
    for (int p = 1; p >= 0; p--) begin
      i_pwm_on = p[0];
      w = 16'($random(seed)) | (16'h0041 << (8 * p));
      for (int i = 0; q.size() < 9; i++) if (w[8 * p + i % 7]) q.push_back(ORD[i % 7]);
      put(w);
      check(o_conv_channel_select_cfg, w);
      for (k = 0; q.size() > 0 && k < 900; k++) @(negedge i_clock);
      check(16'(q.size()), 16'h0000);
      put(16'h0000);
      for (k = 0; o_busy !== 1'b0 && k < 40; k++) @(negedge i_clock);
      check(16'(o_busy), 16'h0000);
    end
    // second reset after activity: a write during reset must not land
    i_sys_rst = 1'b1;
    put(16'h4141);
    @(negedge i_clock);
    i_sys_rst = 1'b0;
    check(o_conv_channel_select_cfg, 16'h0000);
    for (int j = 1; j <= 7; j++) check(16'(s[j]), 16'h0000);
    report_and_stop();
  end
endmodule // tb_adcrr_channel_select
`default_nettype wire
